// ==== logic/uefm_pkg.sv ====
// Package with register map, field positions, timing and carriers for the USB event flag block
package uefm_pkg;

  // ***************************************************************
  // Register map (byte offsets)
  // ***************************************************************
  localparam logic [7:0] OFS_FLAGS_MASKS = 8'h00;
  localparam logic [7:0] OFS_NAK_STATUS = 8'h04;
  localparam logic [7:0] OFS_NAK_SELECT = 8'h08;
  localparam logic [7:0] OFS_DONE_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DONE_SELECT = 8'h10;
  localparam logic [7:0] OFS_ZLEN_STATUS = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int FLAG_LSB = 0;
  localparam int MASK_LSB = 8;
  localparam int BIT_SETUP = 0;
  localparam int BIT_STATUS_ARRIVED = 1;
  localparam int BIT_STATUS_DONE = 2;
  localparam int BIT_ZLEN = 3;
  localparam int BIT_SOF = 4;
  localparam int BIT_EP0_DONE = 5;
  localparam int BIT_EP_DONE = 6;
  localparam int BIT_NAK = 7;
  localparam int CTRL_SELF_FRAME = 0;

  // ***************************************************************
  // Reset values and valid-endpoint mask
  // ***************************************************************
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_MASKS = 8'h00;
  localparam logic [7:0] RST_EP = 8'h00;
  localparam logic [7:0] EP_VALID = 8'hfe;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;
  localparam logic RST_WAIT = 1'b1;
  localparam logic RST_SELF_FRAME = 1'b0;
  localparam logic RST_LINE = 1'b0;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned FRAME_TIME_NS = 1000000;
  localparam int unsigned FRAME_CYCLES = FRAME_TIME_NS / CLK_PERIOD_NS;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } uefm_bus_e;

  typedef struct packed {
    logic ep0_setup;
    logic ep0_status_done;
    logic ep0_status_arrived;
    logic ep0_done;
    logic sof_token;
    logic ctrl_rd_status_stage;
    logic [7:0] nak_ep;
    logic [7:0] done_ep;
    logic [7:0] zlen_ep;
  } uefm_events_s;

  typedef struct packed {
    logic nak;
    logic ep_done;
    logic ep0_done;
    logic sof;
    logic zlen;
    logic status_done;
    logic status_arrived;
    logic setup;
  } uefm_irq_s;

endpackage

// ==== logic/uefm_event_flags.sv ====
// Event flags, line masks, per-endpoint status and Avalon-MM register slave
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Mask bit 15 zero lets NAK flag drive NAK line; one blocks it.
// - Mask bit 14 gates other-endpoint transfer flag onto its line.
// - Mask bit 13 gates endpoint-zero transfer flag onto its line.
// - Mask bit 12 gates start-of-frame flag onto frame line.
// - Mask bit 11 gates zero-length flag onto its line.
// - Mask bit 10 gates status-done flag onto its line.
// - Mask bit 9 gates status-arrived flag onto its line.
// - Mask bit 8 gates setup flag onto setup line.
// - Flag bit 7 sets when a non-zero endpoint sends NAK.
// - Only endpoints enabled in the NAK select register set the NAK flag.
// - Writing one to NAK flag clears per-endpoint NAK status.
// - Flag bit 6 sets when a non-zero endpoint enabled in the done select register completes a transfer.
// - Writing one to flag 6 clears per-endpoint transfer status.
// - Flag bit 5 sets when endpoint zero transfer completes.
// - Flag bit 4 sets on frame token, or each counted frame in self mode.
// - Flag bit 3 sets on zero-length packet at a selected endpoint.
// - No zero-length flag for control read status-stage packet.
// - Writing one to flag 3 clears per-endpoint zero-length status.
// - Setup flag sets on setup token for endpoint zero.
// - Status-done flag sets when endpoint-zero status stage completes.
// - Status-arrived flag sets when status packet arrives in control read.
module uefm_event_flags #(
  parameter int unsigned FRAME_CYCLES = uefm_pkg::FRAME_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Controller events
  input wire uefm_pkg::uefm_events_s events,
  // Interrupt lines
  output uefm_pkg::uefm_irq_s irq_lines
);

  // ***************************************************************
  // Storage
  // ***************************************************************
  uefm_pkg::uefm_bus_e bus_state_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] masks_reg;
  logic [7:0] nak_status_reg;
  logic [7:0] nak_select_reg;
  logic [7:0] done_status_reg;
  logic [7:0] done_select_reg;
  logic [7:0] zlen_status_reg;
  logic self_frame_reg;
  logic [31:0] frame_count_reg;
  logic [31:0] readdata_reg;
  logic waitrequest_reg;
  logic line_nak_reg;
  logic line_ep_done_reg;
  logic line_ep0_done_reg;
  logic line_sof_reg;
  logic line_zlen_reg;
  logic line_sdone_reg;
  logic line_sarr_reg;
  logic line_setup_reg;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic req_new;
  logic wr_commit;
  logic lane0;
  logic lane1;
  logic wr_flags;
  logic wr_nak_sel;
  logic wr_done_sel;
  logic wr_ctrl;
  logic [31:0] rd_value;

  assign req_new = (avs_read | avs_write) & (bus_state_reg == uefm_pkg::BUS_IDLE);
  assign wr_commit = avs_write & (bus_state_reg == uefm_pkg::BUS_ACK);
  assign lane0 = avs_byteenable[0];
  assign lane1 = avs_byteenable[1];
  assign wr_flags = wr_commit & (avs_address == uefm_pkg::OFS_FLAGS_MASKS);
  assign wr_nak_sel = wr_commit & (avs_address == uefm_pkg::OFS_NAK_SELECT);
  assign wr_done_sel = wr_commit & (avs_address == uefm_pkg::OFS_DONE_SELECT);
  assign wr_ctrl = wr_commit & (avs_address == uefm_pkg::OFS_CONTROL);

  always_comb begin
    if (avs_address == uefm_pkg::OFS_FLAGS_MASKS) begin
      rd_value = {16'h0000, masks_reg, flags_reg};
    end else if (avs_address == uefm_pkg::OFS_NAK_STATUS) begin
      rd_value = {24'h000000, nak_status_reg};
    end else if (avs_address == uefm_pkg::OFS_NAK_SELECT) begin
      rd_value = {24'h000000, nak_select_reg};
    end else if (avs_address == uefm_pkg::OFS_DONE_STATUS) begin
      rd_value = {24'h000000, done_status_reg};
    end else if (avs_address == uefm_pkg::OFS_DONE_SELECT) begin
      rd_value = {24'h000000, done_select_reg};
    end else if (avs_address == uefm_pkg::OFS_ZLEN_STATUS) begin
      rd_value = {24'h000000, zlen_status_reg};
    end else if (avs_address == uefm_pkg::OFS_CONTROL) begin
      rd_value = {31'h0000_0000, self_frame_reg};
    end else begin
      rd_value = 32'h0000_0000;
    end
  end

  // ***************************************************************
  // Bus handshake
  // ***************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_reg <= uefm_pkg::BUS_IDLE;
    end else begin
      case (bus_state_reg)
        uefm_pkg::BUS_IDLE: begin
          if (req_new) begin
            bus_state_reg <= uefm_pkg::BUS_ACK;
          end
        end
        default: begin
          bus_state_reg <= uefm_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // One wait cycle per request; low for exactly the answer cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest_reg <= uefm_pkg::RST_WAIT;
    end else if (req_new) begin
      waitrequest_reg <= 1'b0;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  // Read data is captured at acceptance so it stands through the answer cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readdata_reg <= uefm_pkg::RST_RDATA;
    end else if (req_new) begin
      readdata_reg <= rd_value;
    end
  end

  // ***************************************************************
  // Software controls
  // ***************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      masks_reg <= uefm_pkg::RST_MASKS;
    end else if (wr_flags && lane1) begin
      masks_reg <= avs_writedata[uefm_pkg::MASK_LSB +: 8];
    end
  end

  // Endpoint zero can never be selected
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nak_select_reg <= uefm_pkg::RST_EP;
    end else if (wr_nak_sel && lane0) begin
      nak_select_reg <= avs_writedata[7:0] & uefm_pkg::EP_VALID;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_select_reg <= uefm_pkg::RST_EP;
    end else if (wr_done_sel && lane0) begin
      done_select_reg <= avs_writedata[7:0] & uefm_pkg::EP_VALID;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      self_frame_reg <= uefm_pkg::RST_SELF_FRAME;
    end else if (wr_ctrl && lane0) begin
      self_frame_reg <= avs_writedata[uefm_pkg::CTRL_SELF_FRAME];
    end
  end

  // ***************************************************************
  // Frame period counter
  // ***************************************************************
  logic frame_tick;

  assign frame_tick = self_frame_reg & (frame_count_reg == FRAME_CYCLES - 1);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_count_reg <= 32'h0000_0000;
    end else if (!self_frame_reg || frame_tick) begin
      frame_count_reg <= 32'h0000_0000;
    end else begin
      frame_count_reg <= frame_count_reg + 32'h0000_0001;
    end
  end

  // ***************************************************************
  // Per-endpoint status
  // ***************************************************************
  logic [7:0] w1c;
  logic [7:0] nak_ev;
  logic [7:0] done_ev;
  logic [7:0] zlen_ev;

  assign w1c = (wr_flags && lane0) ? avs_writedata[uefm_pkg::FLAG_LSB +: 8] : 8'h00;
  assign nak_ev = events.nak_ep & uefm_pkg::EP_VALID;
  assign done_ev = events.done_ep & uefm_pkg::EP_VALID;
  // Zero-length data of a control read status stage is not reported
  assign zlen_ev = events.zlen_ep & ~{7'h00, events.ctrl_rd_status_stage};

  // New events win over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nak_status_reg <= uefm_pkg::RST_EP;
    end else begin
      nak_status_reg <= (w1c[uefm_pkg::BIT_NAK] ? 8'h00 : nak_status_reg) | nak_ev;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_status_reg <= uefm_pkg::RST_EP;
    end else begin
      done_status_reg <= (w1c[uefm_pkg::BIT_EP_DONE] ? 8'h00 : done_status_reg) | done_ev;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      zlen_status_reg <= uefm_pkg::RST_EP;
    end else begin
      zlen_status_reg <= (w1c[uefm_pkg::BIT_ZLEN] ? 8'h00 : zlen_status_reg) | zlen_ev;
    end
  end

  // ***************************************************************
  // Summary flags
  // ***************************************************************
  logic [7:0] set_ev;

  always_comb begin
    set_ev = 8'h00;
    set_ev[uefm_pkg::BIT_NAK] = |(nak_ev & nak_select_reg);
    set_ev[uefm_pkg::BIT_EP_DONE] = |(done_ev & done_select_reg);
    set_ev[uefm_pkg::BIT_EP0_DONE] = events.ep0_done;
    set_ev[uefm_pkg::BIT_SOF] = events.sof_token | frame_tick;
    set_ev[uefm_pkg::BIT_ZLEN] = |(zlen_ev & nak_select_reg);
    set_ev[uefm_pkg::BIT_STATUS_DONE] = events.ep0_status_done;
    set_ev[uefm_pkg::BIT_STATUS_ARRIVED] = events.ep0_status_arrived;
    set_ev[uefm_pkg::BIT_SETUP] = events.ep0_setup;
    flags_next = (flags_reg & ~w1c) | set_ev;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_reg <= uefm_pkg::RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ***************************************************************
  // Interrupt lines
  // ***************************************************************
  // Lines follow the next flag value so they rise in the same cycle as the flag
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_nak_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_nak_reg <= flags_next[uefm_pkg::BIT_NAK] & ~masks_reg[uefm_pkg::BIT_NAK];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_ep_done_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_ep_done_reg <= flags_next[uefm_pkg::BIT_EP_DONE] & ~masks_reg[uefm_pkg::BIT_EP_DONE];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_ep0_done_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_ep0_done_reg <= flags_next[uefm_pkg::BIT_EP0_DONE] & ~masks_reg[uefm_pkg::BIT_EP0_DONE];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_sof_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_sof_reg <= flags_next[uefm_pkg::BIT_SOF] & ~masks_reg[uefm_pkg::BIT_SOF];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_zlen_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_zlen_reg <= flags_next[uefm_pkg::BIT_ZLEN] & ~masks_reg[uefm_pkg::BIT_ZLEN];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_sdone_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_sdone_reg <= flags_next[uefm_pkg::BIT_STATUS_DONE] & ~masks_reg[uefm_pkg::BIT_STATUS_DONE];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_sarr_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_sarr_reg <= flags_next[uefm_pkg::BIT_STATUS_ARRIVED] & ~masks_reg[uefm_pkg::BIT_STATUS_ARRIVED];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_setup_reg <= uefm_pkg::RST_LINE;
    end else begin
      line_setup_reg <= flags_next[uefm_pkg::BIT_SETUP] & ~masks_reg[uefm_pkg::BIT_SETUP];
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  assign irq_lines = uefm_pkg::uefm_irq_s'({line_nak_reg, line_ep_done_reg, line_ep0_done_reg, line_sof_reg,
                                            line_zlen_reg, line_sdone_reg, line_sarr_reg, line_setup_reg});

endmodule

// ==== verif/uefm_irq_sink.sv ====
// Interrupt controller model that records every raised line
`timescale 1ns/1ps
module uefm_irq_sink (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Lines in, record out
  input wire uefm_pkg::uefm_irq_s irq_lines,
  output logic [7:0] seen
);
  // ****
  // Sticky record of lines
  // ****
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seen <= 8'h00;
    end else begin
      seen <= seen | irq_lines;
    end
  end
endmodule

// ==== verif/uefm_event_flags_assertions.sv ====
// Port checker for the event flag block
`timescale 1ns/1ps
module uefm_event_flags_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events and lines
  input wire uefm_pkg::uefm_events_s events,
  input wire uefm_pkg::uefm_irq_s irq_lines
);
  // ****
  // Mask shadow and properties
  // ****
  logic [7:0] mask_reg;
  logic wr0;
  assign wr0 = avs_write && !avs_waitrequest && avs_address == uefm_pkg::OFS_FLAGS_MASKS;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= 8'h00;
    end else if (wr0 && avs_byteenable[1]) begin
      mask_reg <= avs_writedata[15:8];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_mask_wr; wr0 && avs_byteenable[1]; endsequence
  sequence s_nak_clr; wr0 && avs_byteenable[0] && avs_writedata[7] && events.nak_ep == 8'h00; endsequence
  property p_mask; s_mask_wr ##2 1'b1 |-> (irq_lines & $past(avs_writedata[15:8], 2)) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("masked line active");
  property p_setup; events.ep0_setup && !mask_reg[0] |=> irq_lines.setup; endproperty
  a_setup: assert property (p_setup) else $error("setup line missing");
  property p_sarr; events.ep0_status_arrived && !mask_reg[1] |=> irq_lines.status_arrived; endproperty
  a_sarr: assert property (p_sarr) else $error("status arrived line missing");
  property p_sdone; events.ep0_status_done && !mask_reg[2] |=> irq_lines.status_done; endproperty
  a_sdone: assert property (p_sdone) else $error("status done line missing");
  property p_sof; events.sof_token && !mask_reg[4] |=> irq_lines.sof; endproperty
  a_sof: assert property (p_sof) else $error("frame line missing");
  property p_ep0; events.ep0_done && !mask_reg[5] |=> irq_lines.ep0_done; endproperty
  a_ep0: assert property (p_ep0) else $error("ep0 line missing");
  property p_hold; irq_lines.ep0_done && !mask_reg[5] && !wr0 |=> irq_lines.ep0_done; endproperty
  a_hold: assert property (p_hold) else $error("ep0 line dropped");
  property p_clr; s_nak_clr |=> !irq_lines.nak; endproperty
  a_clr: assert property (p_clr) else $error("nak line not cleared");
endmodule
bind uefm_event_flags uefm_event_flags_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .events(events), .irq_lines(irq_lines));

// ==== verif/tb_usb_device_event_flag_mask.sv ====
// Testbench for the event flag block
`timescale 1ns/1ps
module tb_usb_device_event_flag_mask;
  // ****
  // Signals, tasks and tests
  // ****
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  uefm_pkg::uefm_events_s events = '0;
  uefm_pkg::uefm_irq_s irq_lines;
  uefm_pkg::uefm_events_s e;
  logic [7:0] seen;
  logic [31:0] exp_q[$];
  int fails = 0;
  int n_checks = 0;
  logic [7:0] m;
  logic [7:0] f;
  int bits[5] = '{0, 1, 2, 4, 5};
  uefm_event_flags #(.FRAME_CYCLES(20)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .events(events), .irq_lines(irq_lines));
  uefm_irq_sink sink_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_lines(irq_lines), .seen(seen));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    int k = 0;
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 40) begin
      fails++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic pulse(input uefm_pkg::uefm_events_s ev);
    @(posedge sys_clk);
    events <= ev;
    @(posedge sys_clk);
    events <= '0;
    @(negedge sys_clk);
  endtask
  function automatic uefm_pkg::uefm_events_s one_ev(input int b, input logic [7:0] v);
    uefm_pkg::uefm_events_s ev;
    ev = '0;
    case (b)
      0: ev.ep0_setup = 1'b1;
      1: ev.ep0_status_arrived = 1'b1;
      2: ev.ep0_status_done = 1'b1;
      4: ev.sof_token = 1'b1;
      5: ev.ep0_done = 1'b1;
      7: ev.nak_ep = v;
      6: ev.done_ep = v;
      default: ev.zlen_ep = v;
    endcase
    return ev;
  endfunction
  task automatic ep_kind(input int b, input logic [7:0] st, input logic [7:0] sel);
    logic [7:0] fb;
    fb = 8'h01 << b;
    bus(1'b1, sel, 32'h04, 4'h1);
    pulse(one_ev(b, 8'h08));
    rd(st, 32'h08);
    rd(uefm_pkg::OFS_FLAGS_MASKS, 32'h0);
    pulse(one_ev(b, 8'h04));
    chk("lines", {24'h0, fb}, {24'h0, irq_lines});
    rd(uefm_pkg::OFS_FLAGS_MASKS, {24'h0, fb});
    bus(1'b1, uefm_pkg::OFS_FLAGS_MASKS, {24'h0, fb}, 4'h1);
    rd(st, 32'h0);
  endtask
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk("readdata", exp_q.pop_front(), avs_readdata);
    end
  end
  initial begin
    void'($urandom(32'h44dfce95));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(1'b1, 8'h1c, 32'hffffffff, 4'hf);
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
    $display("test reset done");
    for (int p = 0; p < 3; p++) begin
      m = (p == 0) ? 8'hff : (p == 1) ? 8'($urandom) : 8'h00;
      bus(1'b1, uefm_pkg::OFS_FLAGS_MASKS, {16'h0, m, 8'h00}, 4'h2);
      f = 8'h00;
      foreach (bits[i]) begin
        pulse(one_ev(bits[i], 8'h00));
        f[bits[i]] = 1'b1;
        chk("lines", {24'h0, f & ~m}, {24'h0, irq_lines});
      end
      rd(uefm_pkg::OFS_FLAGS_MASKS, {16'h0, m, f});
      bus(1'b1, uefm_pkg::OFS_FLAGS_MASKS, 32'h000000ff, 4'h3);
      @(negedge sys_clk);
      chk("lines", 32'h0, {24'h0, irq_lines});
    end
    $display("test masks done");
    ep_kind(7, uefm_pkg::OFS_NAK_STATUS, uefm_pkg::OFS_NAK_SELECT);
    ep_kind(6, uefm_pkg::OFS_DONE_STATUS, uefm_pkg::OFS_DONE_SELECT);
    ep_kind(3, uefm_pkg::OFS_ZLEN_STATUS, uefm_pkg::OFS_NAK_SELECT);
    e = one_ev(3, 8'h01);
    e.ctrl_rd_status_stage = 1'b1;
    pulse(e);
    rd(uefm_pkg::OFS_ZLEN_STATUS, 32'h0);
    pulse(one_ev(3, 8'h01));
    rd(uefm_pkg::OFS_ZLEN_STATUS, 32'h01);
    $display("test endpoints done");
    bus(1'b1, uefm_pkg::OFS_CONTROL, 32'h1, 4'h1);
    repeat (24) @(posedge sys_clk);
    bus(1'b1, uefm_pkg::OFS_CONTROL, 32'h0, 4'h1);
    rd(uefm_pkg::OFS_FLAGS_MASKS, 32'h10);
    chk("seen", 32'hff, {24'h0, seen});
    $display("test frame done");
    complete_run();
  end
endmodule
